// >>> isc_pkg.sv
/*
  Package for the I2C SCL timing and bus idle timeout block: register
  offsets, field positions, reset values, fixed timing tables and carriers.
  Assumes a 32-bit AHB-Lite register bus and a single 125 MHz clock.
*/
package isc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COMMAND = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DIVIDER = 8'h0C;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_MASTER_BIT = 1;
  localparam int CTL_RATIO_LSB = 8;
  localparam int CTL_TOSEL_LSB = 12;
  localparam int CTL_IDLE_ON_TO_BIT = 15;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_WMASK = 32'h0000_B303;

  // Command register bits (write only, self clearing)
  localparam int CMD_ABORT_BIT = 0;

  // Status register bits
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_SCL_BIT = 1;
  localparam int STS_SDA_BIT = 2;

  // Interrupt flag bits
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_START_BIT = 1;
  localparam int IRQ_STOP_BIT = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // SCL timing
  // ----------------------------------------------------------------
  localparam int DIV_W = 9;
  localparam logic [DIV_W-1:0] DIV_RESET = 9'h000;
  localparam int CNT_W = 16;
  localparam logic [1:0] RATIO_STD = 2'h0;
  localparam logic [1:0] RATIO_ASYM = 2'h1;
  localparam logic [1:0] RATIO_FAST = 2'h2;
  localparam logic [3:0] NLOW_STD = 4'h4;
  localparam logic [3:0] NHIGH_STD = 4'h4;
  localparam logic [3:0] NLOW_ASYM = 4'h6;
  localparam logic [3:0] NHIGH_ASYM = 4'h3;
  localparam logic [3:0] NLOW_FAST = 4'hB;
  localparam logic [3:0] NHIGH_FAST = 4'h6;
  localparam logic [DIV_W-1:0] DIV_FIXED_MAX = 9'h002;
  localparam logic [3:0] HOLD_BASE = 4'h4;
  // Clocks from releasing SCL until the filtered level can show it high
  localparam logic [CNT_W-1:0] SCL_SEEN_LAT = 16'h0005;

  // Fixed low/high periods for divider 0,1,2: [ratio][div]
  localparam logic [7:0] FIX_LOW [3][3] = '{
    '{8'h07, 8'h0A, 8'h0F},
    '{8'h09, 8'h0E, 8'h15},
    '{8'h0E, 8'h18, 8'h24}};
  localparam logic [7:0] FIX_HIGH [3][3] = '{
    '{8'h07, 8'h0A, 8'h0F},
    '{8'h06, 8'h08, 8'h0C},
    '{8'h09, 8'h0E, 8'h15}};

  // ----------------------------------------------------------------
  // Idle timeout
  // ----------------------------------------------------------------
  localparam logic [1:0] TOSEL_OFF = 2'h0;
  localparam logic [1:0] TOSEL_40 = 2'h1;
  localparam logic [1:0] TOSEL_80 = 2'h2;
  localparam logic [1:0] TOSEL_160 = 2'h3;
  localparam logic [7:0] TO_40_CYC = 8'h28;
  localparam logic [7:0] TO_80_CYC = 8'h50;
  localparam logic [7:0] TO_160_CYC = 8'hA0;

  // Synchronised bus view
  typedef struct packed {
    logic scl;
    logic sda;
  } isc_bus_t;

  // Bus events
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } isc_evt_t;

endpackage

// >>> isc_sync.sv
/*
  Three-stage synchroniser with agreement filter for one bus pin.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
module isc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Chain; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_o <= 1'b1;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end

endmodule

// >>> isc_top.sv
/*
  I2C SCL clock generator with data hold limit and bus idle timeout,
  behind an AHB-Lite register slave with a sticky interrupt.
  Assumes open-drain SCL/SDA pins resolved outside; one clock domain.
*/
// Function
// - Divider 3 and up: SCL high N_high*(div+1), low N_low*(div+1) clocks.
// - Dividers 0, 1, 2 use fixed low/high period table per ratio.
// - Data hold after SCL fall lasts at most 4 plus divider clocks.
// - Busy: timer restarts on SCL rise, flags timeout, repeats while high.
// - Timeout starts on START, stops on STOP, abort, or timeout-idle.
// - Timeout select 0 disables, 1 selects 40 prescaled cycles.
// - Ratio field: 0 gives 4:4, 1 gives 6:3, 2 gives 11:6.
`timescale 1ns/1ps
module isc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // I2C pins (open drain: oe high pulls low)
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Transmit bit from the transfer engine
  input wire logic tx_bit,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [31:0] ctl_q;
  logic [isc_pkg::DIV_W-1:0] div_q;
  logic [isc_pkg::IRQ_W-1:0] flag_q;
  logic [isc_pkg::IRQ_W-1:0] mask_q;
  logic [isc_pkg::IRQ_W-1:0] evt_set;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic abort_q;
  logic busy_q;
  isc_pkg::isc_bus_t bus;
  isc_pkg::isc_evt_t evt;
  logic wr_go;
  logic rd_go;

  assign wr_go = hsel && hready && htrans[1] && hwrite;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;

  // Zero wait state slave, always OKAY
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Capture the address phase of a write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_go;
      if (wr_go) begin
        wr_addr_q <= haddr;
      end
    end
  end

  // Control, divider and mask registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_q <= isc_pkg::CTL_RESET;
      div_q <= isc_pkg::DIV_RESET;
      mask_q <= '0;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        isc_pkg::OFF_CONTROL: ctl_q <= hwdata & isc_pkg::CTL_WMASK;
        isc_pkg::OFF_DIVIDER: div_q <= hwdata[isc_pkg::DIV_W-1:0];
        isc_pkg::OFF_IRQ_MASK: mask_q <= hwdata[isc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Abort command pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= wr_pend_q && (wr_addr_q == isc_pkg::OFF_COMMAND) && hwdata[isc_pkg::CMD_ABORT_BIT];
    end
  end

  // Sticky flags; hardware set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else if (wr_pend_q && wr_addr_q == isc_pkg::OFF_IRQ_FLAG) begin
      flag_q <= (flag_q & ~hwdata[isc_pkg::IRQ_W-1:0]) | evt_set;
    end else begin
      flag_q <= flag_q | evt_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((flag_q | evt_set) & mask_q);
    end
  end

  // Read data, registered in the data phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (haddr)
        isc_pkg::OFF_CONTROL: hrdata <= ctl_q;
        isc_pkg::OFF_STATUS: hrdata <= {29'h0, bus.sda, bus.scl, busy_q};
        isc_pkg::OFF_DIVIDER: hrdata <= {23'h0, div_q};
        isc_pkg::OFF_IRQ_FLAG: hrdata <= {29'h0, flag_q};
        isc_pkg::OFF_IRQ_MASK: hrdata <= {29'h0, mask_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_d1_q;
  logic sda_d1_q;

  isc_sync u_sync_scl (
    .clk(clk),
    .rst_n(rst_n),
    .pin_i(scl_i),
    .level_o(scl_s)
  );

  isc_sync u_sync_sda (
    .clk(clk),
    .rst_n(rst_n),
    .pin_i(sda_i),
    .level_o(sda_s)
  );

  assign bus.scl = scl_s;
  assign bus.sda = sda_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  assign evt.start = scl_s && scl_d1_q && sda_d1_q && !sda_s;
  assign evt.stop = scl_s && scl_d1_q && !sda_d1_q && sda_s;
  assign evt.scl_rise = scl_s && !scl_d1_q;
  assign evt.scl_fall = !scl_s && scl_d1_q;

  // ----------------------------------------------------------------
  // Bus busy state and idle timeout
  // ----------------------------------------------------------------
  logic [1:0] tosel;
  logic [7:0] to_lim;
  logic [7:0] to_cnt_q;
  logic [isc_pkg::DIV_W-1:0] to_pre_q;
  logic to_hit;
  logic en;

  assign en = ctl_q[isc_pkg::CTL_EN_BIT];
  assign tosel = ctl_q[isc_pkg::CTL_TOSEL_LSB +: 2];

  // Timeout length in prescaled cycles
  always_comb begin
    unique case (tosel)
      isc_pkg::TOSEL_40: to_lim = isc_pkg::TO_40_CYC;
      isc_pkg::TOSEL_80: to_lim = isc_pkg::TO_80_CYC;
      isc_pkg::TOSEL_160: to_lim = isc_pkg::TO_160_CYC;
      default: to_lim = 8'h00;
    endcase
  end

  assign to_hit = busy_q && (tosel != isc_pkg::TOSEL_OFF) && scl_s && (to_cnt_q == to_lim - 8'h01)
    && (to_pre_q == div_q);

  // Timer restarts on SCL rise, counts while high; wraps so the flag repeats
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      to_cnt_q <= 8'h00;
      to_pre_q <= '0;
    end else if (!busy_q || evt.scl_rise || !scl_s) begin
      to_cnt_q <= 8'h00;
      to_pre_q <= '0;
    end else if (to_pre_q == div_q) begin
      to_pre_q <= '0;
      to_cnt_q <= to_hit ? 8'h00 : to_cnt_q + 8'h01;
    end else begin
      to_pre_q <= to_pre_q + isc_pkg::DIV_W'(1);
    end
  end

  // Busy tracking: START sets, STOP/abort/timeout-idle clears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (!en) begin
      busy_q <= 1'b0;
    end else if (evt.start) begin
      busy_q <= 1'b1;
    end else if (evt.stop || abort_q) begin
      busy_q <= 1'b0;
    end else if (to_hit && ctl_q[isc_pkg::CTL_IDLE_ON_TO_BIT]) begin
      busy_q <= 1'b0;
    end
  end

  assign evt_set = {evt.stop, evt.start, to_hit};

  // ----------------------------------------------------------------
  // SCL generation
  // ----------------------------------------------------------------
  logic [1:0] ratio;
  logic [3:0] n_low;
  logic [3:0] n_high;
  logic [isc_pkg::CNT_W-1:0] t_low;
  logic [isc_pkg::CNT_W-1:0] t_high;
  logic [isc_pkg::CNT_W-1:0] per_q;
  logic scl_drv_q;
  logic gen;

  assign ratio = ctl_q[isc_pkg::CTL_RATIO_LSB +: 2];
  assign gen = en && ctl_q[isc_pkg::CTL_MASTER_BIT];

  // Ratio selection
  always_comb begin
    unique case (ratio)
      isc_pkg::RATIO_ASYM: begin
        n_low = isc_pkg::NLOW_ASYM;
        n_high = isc_pkg::NHIGH_ASYM;
      end
      isc_pkg::RATIO_FAST: begin
        n_low = isc_pkg::NLOW_FAST;
        n_high = isc_pkg::NHIGH_FAST;
      end
      default: begin
        n_low = isc_pkg::NLOW_STD;
        n_high = isc_pkg::NHIGH_STD;
      end
    endcase
  end

  // Period lengths in clocks; fixed table for small dividers
  always_comb begin
    logic [1:0] r;
    r = (ratio == 2'h3) ? 2'h0 : ratio;
    if (div_q <= isc_pkg::DIV_FIXED_MAX) begin
      t_low = {8'h00, isc_pkg::FIX_LOW[r][div_q[1:0]]};
      t_high = {8'h00, isc_pkg::FIX_HIGH[r][div_q[1:0]]};
    end else begin
      t_low = isc_pkg::CNT_W'(n_low * (div_q + 10'h001));
      t_high = isc_pkg::CNT_W'(n_high * (div_q + 10'h001));
    end
  end

  // Low/high phase counter; high phase waits while another device stretches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_drv_q <= 1'b1;
      per_q <= '0;
    end else if (!gen || !busy_q) begin
      scl_drv_q <= 1'b1;
      per_q <= '0;
    end else if (!scl_drv_q) begin
      if (per_q >= t_low - 16'h0001) begin
        scl_drv_q <= 1'b1;
        per_q <= '0;
      end else begin
        per_q <= per_q + 16'h0001;
      end
    end else if (!scl_s && per_q >= isc_pkg::SCL_SEEN_LAT) begin
      // Count through the filter delay so an unstretched high phase is exactly t_high
      per_q <= per_q; // Stretched
    end else if (per_q >= t_high - 16'h0001) begin
      scl_drv_q <= 1'b0;
      per_q <= '0;
    end else begin
      per_q <= per_q + 16'h0001;
    end
  end

  // Data hold: new SDA value presented within 4+div clocks of SCL fall
  // Timed from our own SCL pull-down; the pin filter delay alone would break the limit
  logic [isc_pkg::DIV_W:0] hold_q;
  logic sda_drv_q;
  logic drv_fall;

  assign drv_fall = gen && !scl_drv_q && !scl_oe;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q <= '0;
      sda_drv_q <= 1'b1;
    end else if (drv_fall) begin
      hold_q <= {1'b0, div_q} + 10'(isc_pkg::HOLD_BASE) - 10'h003;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - (isc_pkg::DIV_W+1)'(1);
      if (hold_q == 10'h001) begin
        sda_drv_q <= tx_bit;
      end
    end
  end

  // Pin outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= !scl_drv_q;
      sda_oe <= gen && !sda_drv_q;
    end
  end

  // Open drain: driven level is always low, only the enables move
  always_ff @(posedge clk) begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_busy_start: assert property (@(posedge clk) disable iff (!rst_n)
    en && evt.start |=> busy_q) else $error("busy not set on start");
  a_busy_stop: assert property (@(posedge clk) disable iff (!rst_n)
    evt.stop && !evt.start |=> !busy_q) else $error("busy not cleared on stop");
  a_idle_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    to_hit && ctl_q[isc_pkg::CTL_IDLE_ON_TO_BIT] && !evt.start |=> !busy_q)
    else $error("timeout did not idle bus");
  a_keep_busy: assert property (@(posedge clk) disable iff (!rst_n)
    to_hit && en && !ctl_q[isc_pkg::CTL_IDLE_ON_TO_BIT] && !evt.stop && !abort_q |=> busy_q)
    else $error("timeout changed bus state");
  a_to_off: assert property (@(posedge clk) disable iff (!rst_n)
    tosel == isc_pkg::TOSEL_OFF |-> !to_hit) else $error("timeout while disabled");
  a_to_flag: assert property (@(posedge clk) disable iff (!rst_n)
    to_hit |=> flag_q[isc_pkg::IRQ_TIMEOUT_BIT]) else $error("timeout flag not set");
  a_hold_limit: assert property (@(posedge clk) disable iff (!rst_n)
    drv_fall |=> hold_q != '0 && hold_q < {1'b0, div_q} + 10'(isc_pkg::HOLD_BASE)) else $error("hold too long");
  a_low_len: assert property (@(posedge clk) disable iff (!rst_n)
    !scl_drv_q && gen && busy_q |-> per_q < t_low) else $error("low phase overrun");
  a_ratio_fast: assert property (@(posedge clk) disable iff (!rst_n)
    ratio == isc_pkg::RATIO_FAST |-> n_low == 4'hB && n_high == 4'h6) else $error("fast ratio");
  a_fix_std0: assert property (@(posedge clk) disable iff (!rst_n)
    div_q == '0 && ratio == isc_pkg::RATIO_STD |-> t_low == 16'h0007) else $error("fixed period");

endmodule

// >>> isc_bus_model.sv
/*
  Peer on the I2C bus: pull-ups, wired-AND lines, START and STOP maker and
  a clock-low pulse. Assumes the device pulls a line low while its oe is high.
*/
`timescale 1ns/1ps
module isc_bus_model (
  // Clock
  input wire logic clk,
  // Device pull-downs
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Resolved lines
  output logic scl,
  output logic sda
);
  logic peer_scl_low = 1'b0;
  logic peer_sda_low = 1'b0;

  // ----------------------------------------------------------------
  // Wired-AND lines with pull-ups
  // ----------------------------------------------------------------
  // A released line floats back to one, never to its last driven value
  assign scl = !(scl_oe || peer_scl_low);
  assign sda = !(sda_oe || peer_sda_low);

  // SDA falls while SCL is high; held low so no STOP follows at once
  task automatic start_cond();
    while (scl !== 1'b1) @(posedge clk);
    peer_sda_low <= 1'b1;
    @(posedge clk);
  endtask

  // SDA rises while SCL is high
  task automatic stop_cond();
    @(posedge clk);
    while (scl !== 1'b1) @(posedge clk);
    peer_sda_low <= 1'b0;
    @(posedge clk);
  endtask

  // Slow peer: holds SCL low for n cycles, then lets it rise again
  task automatic pulse_scl(input int n);
    peer_scl_low <= 1'b1;
    repeat (n) @(posedge clk);
    peer_scl_low <= 1'b0;
  endtask
endmodule

// >>> tb_isc_top.sv
/*
  Self-checking bench for isc_top: SCL timing table, data hold, idle
  timeout, interrupt and registers. Assumes the bus peer in isc_bus_model.
*/
`timescale 1ns/1ps
module tb_isc_top;
  typedef struct packed {
    logic [1:0] ratio;
    logic [8:0] div;
    logic [7:0] lo;
    logic [7:0] hi;
  } isc_row_t;

  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, tx_bit, irq;
  logic scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  int failures = 0;
  int n_checks = 0;
  int lo, hi, cnt;
  // Expected low/high clocks per ratio and divider; divider 3 follows N*(div+1)
  isc_row_t rows [13] = '{
    '{2'h0, 9'h000, 8'h07, 8'h07}, '{2'h0, 9'h001, 8'h0A, 8'h0A}, '{2'h0, 9'h002, 8'h0F, 8'h0F},
    '{2'h1, 9'h000, 8'h09, 8'h06}, '{2'h1, 9'h001, 8'h0E, 8'h08}, '{2'h1, 9'h002, 8'h15, 8'h0C},
    '{2'h2, 9'h000, 8'h0E, 8'h09}, '{2'h2, 9'h001, 8'h18, 8'h0E}, '{2'h2, 9'h002, 8'h24, 8'h15},
    '{2'h0, 9'h003, 8'h10, 8'h10}, '{2'h1, 9'h003, 8'h18, 8'h0C}, '{2'h2, 9'h003, 8'h2C, 8'h18},
    '{2'h3, 9'h000, 8'h07, 8'h07}};

  assign hready = hreadyout;

  // ----------------------------------------------------------------
  // Design, bus peer, clock
  // ----------------------------------------------------------------
  isc_top isc_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .tx_bit(tx_bit), .irq(irq));
  isc_bus_model isc_bus_model_i (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl_i), .sda(sda_i));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask

  // One AHB-Lite single word transfer; waits on hready, no cycle count assumed
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk(x & m, exp, msg);
  endtask

  // Counts a full SCL low then high phase as driven by the device
  task automatic measure(output int l, output int h);
    l = 0;
    h = 0;
    while (scl_oe !== 1'b0) @(posedge clk);
    while (scl_oe !== 1'b1) @(posedge clk);
    while (scl_oe === 1'b1) begin
      l++;
      @(posedge clk);
    end
    while (scl_oe === 1'b0) begin
      h++;
      @(posedge clk);
    end
  endtask

  // Cycles until irq rises after having been low, bounded
  task automatic wait_irq(output int n);
    logic low_seen;
    n = 0;
    low_seen = 1'b0;
    while (!(low_seen && irq === 1'b1) && n < 400) begin
      if (irq === 1'b0) low_seen = 1'b1;
      @(posedge clk);
      n++;
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog well above the few thousand cycles the run needs
  initial begin
    #(8 * 60000);
    failures++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    tx_bit = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(isc_pkg::OFF_CONTROL, 32'hFFFF_FFFF, isc_pkg::CTL_RESET, "control reset");
    // Master timing per row; abort after enable since busy may be stale
    for (int i = 0; i < 13; i++) begin
      wr(isc_pkg::OFF_DIVIDER, 32'(rows[i].div));
      wr(isc_pkg::OFF_CONTROL, 32'h0000_0003 | (32'(rows[i].ratio) << 8));
      wr(isc_pkg::OFF_COMMAND, 32'h0000_0001);
      isc_bus_model_i.start_cond();
      measure(lo, hi);
      measure(lo, hi);
      chk(32'(lo), 32'(rows[i].lo), "scl low clocks");
      chk(32'(hi), 32'(rows[i].hi), "scl high clocks");
      isc_bus_model_i.stop_cond();
      repeat (8) @(posedge clk);
      rdchk(isc_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "busy after stop");
    end
    // Data hold: SDA follows tx_bit soon after an SCL fall
    isc_bus_model_i.start_cond();
    while (scl_oe !== 1'b0) @(posedge clk);
    tx_bit <= 1'b0;
    while (scl_oe !== 1'b1) @(posedge clk);
    cnt = 1;
    while (sda_oe !== 1'b1 && cnt < 20) begin
      cnt++;
      @(posedge clk);
    end
    // Divider 0: SDA must move within 4 clocks of SCL being pulled low
    chk(32'(cnt <= 5), 32'h0000_0001, "data hold span");
    tx_bit <= 1'b1;
    wr(isc_pkg::OFF_COMMAND, 32'h0000_0001);
    wr(isc_pkg::OFF_CONTROL, 32'h0000_0000);
    isc_bus_model_i.stop_cond();
    // Idle timeout as slave, divider 1: 40 prescaled cycles are 80 clocks
    wr(isc_pkg::OFF_IRQ_FLAG, 32'h0000_0007);
    wr(isc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(isc_pkg::OFF_DIVIDER, 32'h0000_0001);
    wr(isc_pkg::OFF_CONTROL, 32'h0000_1001);
    isc_bus_model_i.start_cond();
    wait_irq(cnt);
    chk(32'(cnt >= 79 && cnt <= 95), 32'h0000_0001, "first timeout");
    rdchk(isc_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001, "busy kept");
    wr(isc_pkg::OFF_IRQ_FLAG, 32'h0000_0001);
    wait_irq(cnt);
    chk(32'(cnt >= 66 && cnt <= 82), 32'h0000_0001, "repeat timeout");
    wr(isc_pkg::OFF_IRQ_FLAG, 32'h0000_0001);
    repeat (40) @(posedge clk);
    isc_bus_model_i.pulse_scl(4);
    wait_irq(cnt);
    chk(32'(cnt >= 79 && cnt <= 95), 32'h0000_0001, "timer restart");
    wr(isc_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    wr(isc_pkg::OFF_IRQ_FLAG, 32'h0000_0001);
    repeat (100) @(posedge clk);
    chk(32'(irq), 32'h0000_0000, "masked irq");
    rdchk(isc_pkg::OFF_IRQ_FLAG, 32'h0000_0001, 32'h0000_0001, "masked flag");
    wr(isc_pkg::OFF_CONTROL, 32'h0000_9001);
    repeat (100) @(posedge clk);
    rdchk(isc_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "idle on timeout");
    isc_bus_model_i.stop_cond();
    // Select 0 never times out; abort ends the busy period
    wr(isc_pkg::OFF_IRQ_FLAG, 32'h0000_0007);
    wr(isc_pkg::OFF_CONTROL, 32'h0000_0001);
    isc_bus_model_i.start_cond();
    repeat (250) @(posedge clk);
    rdchk(isc_pkg::OFF_IRQ_FLAG, 32'h0000_0001, 32'h0000_0000, "timeout off");
    rdchk(isc_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001, "busy held");
    wr(isc_pkg::OFF_COMMAND, 32'h0000_0001);
    repeat (6) @(posedge clk);
    rdchk(isc_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "abort idles");
    isc_bus_model_i.stop_cond();
    // Register widths and an unmapped place
    wr(isc_pkg::OFF_DIVIDER, 32'hFFFF_FFFF);
    rdchk(isc_pkg::OFF_DIVIDER, 32'hFFFF_FFFF, 32'h0000_01FF, "divider width");
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk({25'h0, hreadyout, hresp, scl_o, sda_o, scl_oe, sda_oe, irq}, 32'h0000_0040, "pins after reset");
    rdchk(isc_pkg::OFF_DIVIDER, 32'hFFFF_FFFF, 32'(isc_pkg::DIV_RESET), "divider reset");
    print_verdict();
  end
endmodule
